// ---- rtl/anp_page_store.sv ----
`timescale 1ns/100ps
`include "anp_params.svh"

module anp_page_store
(
    input  wire logic               clk_sys,  // Core clock
    input  wire logic               rst_b,    // Async reset, active low
    input  wire logic               cap,      // Received page strobe
    input  wire anp_pkg::anp_page_t cap_page, // Received 48-bit page
    input  wire logic               rd_en,    // Read one word
    input  wire anp_pkg::anp_rx_idx_t rd_idx, // Word selector
    output anp_pkg::anp_word_t      rd_word   // Registered read word
);

    anp_pkg::anp_page_t live;
    anp_pkg::anp_page_t snap;

    // Latest page from the partner, overwritten by each new one
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            live <= `ANP_PAGE_RESET;
        else if (cap)
            live <= cap_page;
    end

    // Header read freezes the whole page so the other words match it
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            snap <= `ANP_PAGE_RESET;
        else if (rd_en && rd_idx == anp_pkg::ANP_RX_HDR)
            snap <= live;
    end

    // Header comes from the live page, upper words from the snapshot
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rd_word <= `ANP_WORD_RESET;
        else if (rd_en)
        begin
            case (rd_idx)
                anp_pkg::ANP_RX_HDR:
                    rd_word <= live[`ANP_HDR_MSB:0];
                anp_pkg::ANP_RX_MID:
                    rd_word <= snap[`ANP_MID_MSB:`ANP_MID_LSB];
                anp_pkg::ANP_RX_HIGH:
                    rd_word <= snap[`ANP_HIGH_MSB:`ANP_HIGH_LSB];
                default:
                    rd_word <= `ANP_WORD_RESET;
            endcase
        end
    end

endmodule

// ---- rtl/anp_params.svh ----
`ifndef ANP_PARAMS_SVH
`define ANP_PARAMS_SVH

// Management device holding the auto-negotiation registers
`define ANP_DEV_ADDR       5'h07

// Register offsets within the device
`define ANP_OFF_TX_HDR     16'h0016
`define ANP_OFF_TX_MID     16'h0017
`define ANP_OFF_TX_HIGH    16'h0018
`define ANP_OFF_RX_HDR     16'h0019
`define ANP_OFF_RX_MID     16'h001A
`define ANP_OFF_RX_HIGH    16'h001B

// Reset values
`define ANP_TX_HDR_RESET   16'h2000
`define ANP_WORD_RESET     16'h0000
`define ANP_PAGE_RESET     48'h000000000000

// Field positions in the header word (codeword bits D15:D0)
`define ANP_BIT_NP         15
`define ANP_BIT_ACK        14
`define ANP_BIT_MP         13
`define ANP_BIT_ACK2       12
`define ANP_BIT_TOGGLE     11
`define ANP_CODE_MSB       10
`define ANP_CODE_LSB       0

// Word boundaries inside the 48-bit codeword
`define ANP_HDR_MSB        15
`define ANP_MID_LSB        16
`define ANP_MID_MSB        31
`define ANP_HIGH_LSB       32
`define ANP_HIGH_MSB       47

`endif

// ---- rtl/anp_pkg.sv ----
package anp_pkg;

    typedef logic [15:0] anp_word_t;
    typedef logic [47:0] anp_page_t;

    // Which received word a read selects
    typedef enum logic [1:0] {
        ANP_RX_HDR  = 2'b00,
        ANP_RX_MID  = 2'b01,
        ANP_RX_HIGH = 2'b10
    } anp_rx_idx_t;

    // Source of a pending read answer
    typedef enum logic [2:0] {
        ANP_SEL_NONE    = 3'b000,
        ANP_SEL_TX_HDR  = 3'b001,
        ANP_SEL_TX_MID  = 3'b010,
        ANP_SEL_TX_HIGH = 3'b011,
        ANP_SEL_RX      = 3'b100
    } anp_rd_sel_t;

endpackage

// ---- rtl/anp_regs.sv ----
`timescale 1ns/100ps
`include "anp_params.svh"

module anp_regs
(
    input  wire logic               clk_sys,       // Core clock, 125 MHz
    input  wire logic               rst_b,         // Async reset, active low
    input  wire logic [4:0]         mgmt_dev_addr, // Management device
    input  wire logic [15:0]        mgmt_reg_addr, // Register offset
    input  wire logic               mgmt_wr,       // Write strobe
    input  wire anp_pkg::anp_word_t mgmt_wdata,    // Write data
    input  wire logic               mgmt_rd,       // Read strobe
    output anp_pkg::anp_word_t      mgmt_rdata,    // Read data
    output logic                    mgmt_rvalid,   // Read data valid
    input  wire logic               base_done,     // Base page sent pulse
    input  wire logic               base_toggle,   // Toggle of that base page
    input  wire logic               page_sent,     // Next page sent pulse
    output anp_pkg::anp_page_t      tx_page,       // Outgoing codeword
    input  wire logic               rx_page_valid, // Partner page strobe
    input  wire anp_pkg::anp_page_t rx_page        // Partner codeword
);

    // Transmit codeword fields
    logic                tx_more_pages;
    logic                tx_message_page_flag;
    logic                tx_ack2;
    logic                tx_toggle_shadow;
    logic [10:0]         tx_code_field;
    anp_pkg::anp_word_t  tx_code_word_mid;
    anp_pkg::anp_word_t  tx_code_word_high;
    logic                hw_toggle;

    // Read pipeline
    anp_pkg::anp_rd_sel_t rd_sel;
    logic                 rd_pend;
    anp_pkg::anp_word_t   rd_word_tx;
    anp_pkg::anp_word_t   rx_word;

    logic                 store_rd;
    anp_pkg::anp_rx_idx_t store_idx;
    anp_pkg::anp_rd_sel_t next_rd_sel;

    // Address match inside the auto-negotiation device
    function automatic logic hit(input logic [4:0] dev,
                                 input logic [15:0] addr,
                                 input logic [15:0] off);
        hit = (dev == `ANP_DEV_ADDR) && (addr == off);
    endfunction

    // Header word as software sees it; reserved bit 14 reads zero
    function automatic anp_pkg::anp_word_t tx_hdr_word(input logic tog);
        anp_pkg::anp_word_t w;
        w = `ANP_WORD_RESET;
        w[`ANP_BIT_NP] = tx_more_pages;
        w[`ANP_BIT_MP] = tx_message_page_flag;
        w[`ANP_BIT_ACK2] = tx_ack2;
        w[`ANP_BIT_TOGGLE] = tog;
        w[`ANP_CODE_MSB:`ANP_CODE_LSB] = tx_code_field;
        return w;
    endfunction

    // Header fields; write to reserved bit 14 is dropped
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_more_pages        <= 1'(`ANP_TX_HDR_RESET >> `ANP_BIT_NP);
            tx_message_page_flag <= 1'(`ANP_TX_HDR_RESET >> `ANP_BIT_MP);
            tx_ack2              <= 1'(`ANP_TX_HDR_RESET >> `ANP_BIT_ACK2);
            tx_toggle_shadow     <= 1'(`ANP_TX_HDR_RESET >> `ANP_BIT_TOGGLE);
            tx_code_field        <= 11'(`ANP_TX_HDR_RESET);
        end
        else if (mgmt_wr && hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_TX_HDR))
        begin
            tx_more_pages        <= mgmt_wdata[`ANP_BIT_NP];
            tx_message_page_flag <= mgmt_wdata[`ANP_BIT_MP];
            tx_ack2              <= mgmt_wdata[`ANP_BIT_ACK2];
            tx_toggle_shadow     <= mgmt_wdata[`ANP_BIT_TOGGLE];
            tx_code_field        <= mgmt_wdata[`ANP_CODE_MSB:`ANP_CODE_LSB];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            tx_code_word_mid <= `ANP_WORD_RESET;
        else if (mgmt_wr && hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_TX_MID))
            tx_code_word_mid <= mgmt_wdata;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            tx_code_word_high <= `ANP_WORD_RESET;
        else if (mgmt_wr &&
                 hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_TX_HIGH))
            tx_code_word_high <= mgmt_wdata;
    end

    // hardware toggle sequence
    // Base page load wins if both strobes coincide, as it restarts the run
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            hw_toggle <= 1'b0;
        else if (base_done)
            hw_toggle <= ~base_toggle;
        else if (page_sent)
            hw_toggle <= ~hw_toggle;
    end

    // Outgoing codeword; D14 is left zero for the arbitration logic to set
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            // Message page flag already shows in reset, as its field does
            tx_page <= {`ANP_WORD_RESET, `ANP_WORD_RESET, `ANP_TX_HDR_RESET};
        else
        begin
            tx_page <= {tx_code_word_high, tx_code_word_mid,
                        tx_hdr_word(hw_toggle)};
        end
    end

    // Read decode, first cycle of a read
    always_comb
    begin
        next_rd_sel = anp_pkg::ANP_SEL_NONE;
        store_idx   = anp_pkg::ANP_RX_HDR;
        store_rd    = 1'b0;
        if (mgmt_rd)
        begin
            if (hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_TX_HDR))
                next_rd_sel = anp_pkg::ANP_SEL_TX_HDR;
            else if (hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_TX_MID))
                next_rd_sel = anp_pkg::ANP_SEL_TX_MID;
            else if (hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_TX_HIGH))
                next_rd_sel = anp_pkg::ANP_SEL_TX_HIGH;
            else if (hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_RX_HDR))
            begin
                next_rd_sel = anp_pkg::ANP_SEL_RX;
                store_rd    = 1'b1;
            end
            else if (hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_RX_MID))
            begin
                next_rd_sel = anp_pkg::ANP_SEL_RX;
                store_idx   = anp_pkg::ANP_RX_MID;
                store_rd    = 1'b1;
            end
            else if (hit(mgmt_dev_addr, mgmt_reg_addr, `ANP_OFF_RX_HIGH))
            begin
                next_rd_sel = anp_pkg::ANP_SEL_RX;
                store_idx   = anp_pkg::ANP_RX_HIGH;
                store_rd    = 1'b1;
            end
        end
    end

    // Transmit words are staged so every read has the same latency
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_sel     <= anp_pkg::ANP_SEL_NONE;
            rd_pend    <= 1'b0;
            rd_word_tx <= `ANP_WORD_RESET;
        end
        else
        begin
            rd_sel  <= next_rd_sel;
            rd_pend <= mgmt_rd;
            case (next_rd_sel)
                anp_pkg::ANP_SEL_TX_HDR:
                    rd_word_tx <= tx_hdr_word(tx_toggle_shadow);
                anp_pkg::ANP_SEL_TX_MID:
                    rd_word_tx <= tx_code_word_mid;
                anp_pkg::ANP_SEL_TX_HIGH:
                    rd_word_tx <= tx_code_word_high;
                default:
                    rd_word_tx <= `ANP_WORD_RESET;
            endcase
        end
    end

    // Answer register; unmapped reads return zero
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mgmt_rdata  <= `ANP_WORD_RESET;
            mgmt_rvalid <= 1'b0;
        end
        else
        begin
            mgmt_rvalid <= rd_pend;
            case (rd_sel)
                anp_pkg::ANP_SEL_RX:
                    mgmt_rdata <= rx_word;
                anp_pkg::ANP_SEL_NONE:
                    mgmt_rdata <= `ANP_WORD_RESET;
                default:
                    mgmt_rdata <= rd_word_tx;
            endcase
        end
    end

    // partner page held
    // Writes to these offsets are ignored since they never reach the store
    anp_page_store u_store
    (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .cap      (rx_page_valid),
        .cap_page (rx_page),
        .rd_en    (store_rd),
        .rd_idx   (store_idx),
        .rd_word  (rx_word)
    );

endmodule

// ---- testbench/anp_link_partner.sv ----
`timescale 1ns/100ps

module anp_link_partner
(
    input  wire logic               clk_sys,               // Core clock
    input  wire logic               send,                  // Send one page
    input  wire anp_pkg::anp_page_t page,                  // Page to send
    output anp_pkg::anp_page_t      rx_page       = 48'h0, // Page out
    output logic                    rx_page_valid = 1'b0   // Page strobe
);
    // One-cycle strobe per page; off the strobe the word is inverted
    // every cycle so a stale capture cannot pass by luck
    always @(posedge clk_sys)
    begin
        rx_page_valid <= send;
        rx_page       <= send ? page : ~rx_page;
    end
endmodule

// ---- testbench/anp_regs_assertions.sv ----
`timescale 1ns/100ps
`include "anp_params.svh"

module anp_regs_assertions
(
    input wire logic               clk_sys,       // Core clock
    input wire logic               rst_b,         // Reset, active low
    input wire logic [4:0]         mgmt_dev_addr, // Device
    input wire logic [15:0]        mgmt_reg_addr, // Offset
    input wire logic               mgmt_wr,       // Write strobe
    input wire anp_pkg::anp_word_t mgmt_wdata,    // Write data
    input wire logic               mgmt_rd,       // Read strobe
    input wire anp_pkg::anp_word_t mgmt_rdata,    // Read data
    input wire logic               mgmt_rvalid,   // Read valid
    input wire logic               base_done,     // Base page sent
    input wire logic               base_toggle,   // Base page toggle
    input wire logic               page_sent,     // Next page sent
    input wire anp_pkg::anp_page_t tx_page,       // Outgoing page
    input wire logic               rx_page_valid, // Partner strobe
    input wire anp_pkg::anp_page_t rx_page        // Partner page
);
    anp_pkg::anp_word_t rx_hdr;  // Header word of the partner page

    // Header word kept apart so that $past sees a plain signal
    assign rx_hdr = rx_page[15:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Accesses aimed at one register of this device
    sequence s_wr(off);
        mgmt_wr && mgmt_dev_addr == `ANP_DEV_ADDR && mgmt_reg_addr == off;
    endsequence
    sequence s_rd(off);
        mgmt_rd && mgmt_dev_addr == `ANP_DEV_ADDR && mgmt_reg_addr == off;
    endsequence
    // Partner page, then a header read on the next edge
    sequence s_rx_rd;
        rx_page_valid ##1 s_rd(`ANP_OFF_RX_HDR);
    endsequence

    a_hdr_fields: assert property (
        s_wr(`ANP_OFF_TX_HDR) |-> ##2 (tx_page[15:0] & 16'hB7FF) ==
            ($past(mgmt_wdata, 2) & 16'hB7FF))
        else $error("Header write missing from codeword");
    a_mid_word: assert property (
        s_wr(`ANP_OFF_TX_MID) |-> ##2 tx_page[31:16] == $past(mgmt_wdata, 2))
        else $error("Middle word missing from codeword");
    a_high_word: assert property (
        s_wr(`ANP_OFF_TX_HIGH) |-> ##2 tx_page[47:32] == $past(mgmt_wdata, 2))
        else $error("High word missing from codeword");
    a_hdr_read: assert property (
        s_rd(`ANP_OFF_TX_HDR) |-> ##2 mgmt_rvalid && !mgmt_rdata[14])
        else $error("Header read late or reserved bit set");
    a_foreign_zero: assert property (
        mgmt_rd && mgmt_dev_addr != `ANP_DEV_ADDR
            |-> ##2 mgmt_rvalid && mgmt_rdata == 16'h0000)
        else $error("Foreign device read not answered with zero");
    a_toggle_base: assert property (
        base_done |-> ##2 tx_page[11] == !$past(base_toggle, 2))
        else $error("Toggle not loaded from base page");
    a_toggle_flip: assert property (
        page_sent && !base_done |-> ##2 tx_page[11] != $past(tx_page[11]))
        else $error("Toggle did not invert on sent page");
    a_rx_header: assert property (
        s_rx_rd |-> ##2 mgmt_rvalid && mgmt_rdata == $past(rx_hdr, 3))
        else $error("Received header not returned");
endmodule

bind anp_regs anp_regs_assertions u_chk (.*);

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`include "anp_params.svh"

module testbench;
    localparam logic [4:0] dv = `ANP_DEV_ADDR;
    logic               clk_sys       = 1'b0;
    logic               rst_b         = 1'b0;
    logic [4:0]         mgmt_dev_addr = 5'h00;
    logic [15:0]        mgmt_reg_addr = 16'h0000;
    logic               mgmt_wr       = 1'b0;
    anp_pkg::anp_word_t mgmt_wdata    = 16'h0000;
    logic               mgmt_rd       = 1'b0;
    anp_pkg::anp_word_t mgmt_rdata;
    logic               mgmt_rvalid;
    logic               base_done     = 1'b0;
    logic               base_toggle   = 1'b0;
    logic               page_sent     = 1'b0;
    anp_pkg::anp_page_t tx_page;
    logic               rx_page_valid;
    anp_pkg::anp_page_t rx_page;
    logic               lp_send       = 1'b0;
    anp_pkg::anp_page_t lp_page       = 48'h0;
    logic [2:0]         tog_tab [5]   = '{3'h5, 3'h0, 3'h1, 3'h6, 3'h1};
    int                 error_cnt     = 0;
    int                 checks        = 0;
    int                 cyc           = 0;

    anp_regs u_dut (.*);
    anp_link_partner u_lp (.clk_sys(clk_sys), .send(lp_send), .page(lp_page),
        .rx_page(rx_page), .rx_page_valid(rx_page_valid));

    // 125 MHz core clock
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input anp_pkg::anp_page_t seen,
                       input anp_pkg::anp_page_t exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Strobes are one-cycle pulses; the answer stands one cycle only,
    // right after the first edge that follows the sampled strobe
    task automatic acc(input logic w, input logic [4:0] dev,
                       input logic [15:0] off, input anp_pkg::anp_word_t d);
        @(posedge clk_sys);
        mgmt_dev_addr <= dev;
        mgmt_reg_addr <= off;
        mgmt_wdata    <= d;
        mgmt_wr       <= w;
        mgmt_rd       <= !w;
        @(posedge clk_sys);
        mgmt_wr <= 1'b0;
        mgmt_rd <= 1'b0;
        @(posedge clk_sys);
        #1;
        if (!w)
            chk("rvalid", mgmt_rvalid, 1'b1);
        if (!w)
            chk("rdata", mgmt_rdata, d);
    endtask

    // Table entry is base_done, base_toggle, expected toggle
    task automatic tog(input logic [2:0] t);
        @(posedge clk_sys);
        base_done   <= t[2];
        base_toggle <= t[1];
        page_sent   <= !t[2];
        @(posedge clk_sys);
        base_done <= 1'b0;
        page_sent <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("toggle", tx_page[11], t[0]);
    endtask

    task automatic lp(input anp_pkg::anp_page_t p);
        @(posedge clk_sys);
        lp_page <= p;
        lp_send <= 1'b1;
        @(posedge clk_sys);
        lp_send <= 1'b0;
    endtask

    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        chk("tx_page", tx_page, 48'h2000);
        acc(0, dv, 16'h0016, `ANP_TX_HDR_RESET);
        for (int i = 1; i < 6; i++)
            acc(0, dv, 16'h0016 + 16'(i), 16'h0000);
        acc(1, dv, 16'h0016, 16'hFFFF);
        acc(1, dv, 16'h0017, 16'h1234);
        acc(1, dv, 16'h0018, 16'hABCD);
        chk("tx_page", tx_page, 48'hABCD1234B7FF);
        acc(0, dv, 16'h0016, 16'hBFFF);
        acc(1, 5'h01, 16'h0017, 16'h0000);
        acc(1, dv, 16'h0019, 16'hFFFF);
        acc(0, dv, 16'h0017, 16'h1234);
        acc(0, dv, 16'h0018, 16'hABCD);
        acc(0, 5'h01, 16'h0017, 16'h0000);
        acc(0, dv, 16'h0019, 16'h0000);
        acc(0, dv, 16'h001C, 16'h0000);
        acc(1, dv, 16'h0016, 16'h0000);
        for (int i = 0; i < 5; i++)
            tog(tog_tab[i]);
        acc(0, dv, 16'h0016, 16'h0000);
        lp(48'hAAAA5555F9A5);
        acc(0, dv, 16'h0019, 16'hF9A5);
        lp(48'h1111222243C1);
        acc(0, dv, 16'h001A, 16'h5555);
        acc(0, dv, 16'h001B, 16'hAAAA);
        acc(0, dv, 16'h0019, 16'h43C1);
        acc(0, dv, 16'h001A, 16'h2222);
        acc(0, dv, 16'h001B, 16'h1111);
        end_sim();
    end
endmodule
